// [bench/cmpx_exec_sva.sv]
// Concurrent checks on the ports of the compare unit.
module cmpx_exec_chk
   import cmpx_pkg::*;
(
   input wire logic core_clk, // Core clock.
   input wire logic nrst, // Reset, active low.
   input wire logic wb_cyc_i, // Bus cycle.
   input wire logic wb_stb_i, // Bus strobe.
   input wire logic wb_we_i, // Bus write.
   input wire logic [7:0] wb_adr_i, // Bus address.
   input wire logic [3:0] wb_sel_i, // Byte selects.
   input wire logic [31:0] wb_dat_i, // Write data.
   input wire logic [31:0] wb_dat_o, // Read data.
   input wire logic wb_ack_o, // Acknowledge.
   input wire logic busy, // Instruction running.
   input wire logic flag_c, // Carry.
   input wire logic flag_z, // Zero.
   input wire logic flag_s, // Sign.
   input wire logic flag_v // Overflow.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   logic req;
   logic start;
   logic unmapped;
   logic [3:0] flags;
   // Decoded bus events; a request counts until it is acknowledged.
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign start = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
      && wb_sel_i[0] && wb_dat_i[CTRL_START]
      && wb_adr_i[7:2] == ADR_CTRL[7:2];
   assign unmapped = (wb_adr_i >= 8'h24 && wb_adr_i < ADR_GPR0)
      || wb_adr_i >= 8'h80;
   assign flags = {flag_v, flag_s, flag_z, flag_c};

   // Bus handshake: one answer, one cycle after each request.
   ack_latency_a: assert property (disable iff (!nrst)
      req |=> wb_ack_o) else $error("request not acknowledged");
   ack_pulse_a: assert property (disable iff (!nrst)
      wb_ack_o |=> !wb_ack_o) else $error("acknowledge too long");
   ack_cause_a: assert property (disable iff (!nrst)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without request");
   unmapped_zero_a: assert property (disable iff (!nrst)
      req && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // A start while idle launches the run; the run is short and bounded.
   start_busy_a: assert property (disable iff (!nrst)
      start && !busy |=> busy) else $error("start did not raise busy");
   busy_bound_a: assert property (disable iff (!nrst)
      $rose(busy) |-> ##[1:8] !busy) else $error("run too long");
   // Flags move only in the execute state of a run; the past reset guard avoids the
   // false hit on the edge right after reset.
   flags_quiet_a: assert property (
      disable iff (!nrst)
      $past(nrst) && !busy && !$past(busy) |-> $stable(flags))
      else $error("flags changed while idle");
   // Status reads mirror busy and the four flags.
   status_mirror_a: assert property (
      disable iff (!nrst)
      wb_ack_o && !wb_we_i && wb_adr_i[7:2] == ADR_STATUS[7:2]
      |-> wb_dat_o[STAT_BUSY] == $past(busy)
      && wb_dat_o[STAT_V:STAT_C] == $past(flags))
      else $error("status read does not match");
   reset_clear_a: assert property (
      !nrst |=> !wb_ack_o && !busy && flags == 4'h0)
      else $error("reset did not clear outputs");
endmodule : cmpx_exec_chk

bind cmpx_exec cmpx_exec_chk i_cmpx_exec_chk (.core_clk(core_clk),
   .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .busy(busy), .flag_c(flag_c), .flag_z(flag_z), .flag_s(flag_s),
   .flag_v(flag_v));

// [bench/tb_cmpx_exec.sv]
// Register-level bench for the compare unit.
module tb_cmpx_exec
   import cmpx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, busy, flag_c, flag_z, flag_s, flag_v;
   int error_cnt = 0;
   int samples_checked = 0;
   // Filler for instruction words that a form does not use.
   localparam logic [15:0] ZW = 16'h0000;

   cmpx_exec i_cmpx_exec (.core_clk(core_clk), .nrst(nrst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy),
      .flag_c(flag_c), .flag_z(flag_z), .flag_s(flag_s),
      .flag_v(flag_v));

   // Core clock, 8 ns period.
   always #4 core_clk = ~core_clk;

   task automatic summarize;
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One classic cycle; the wait is bounded so a dead slave ends the run.
   task automatic wb_go(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         error_cnt++;
         summarize();
      end
   endtask : wb_go

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_go(1'b1, a, d, q);
   endtask : wr

   task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_go(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask : expect_rd

   // Loads four instruction words, starts, polls done, checks status bits.
   task automatic exec(input logic [15:0] w0, w1, w2, w3,
      input logic [7:0] ctl, input logic [8:0] stat);
      logic [31:0] q;
      int n;
      wr(ADR_IWORD0, {16'h0, w0});
      wr(ADR_IWORD0 + 8'h04, {16'h0, w1});
      wr(ADR_IWORD0 + 8'h08, {16'h0, w2});
      wr(ADR_IWORD0 + 8'h0C, {16'h0, w3});
      wr(ADR_CTRL, {24'h0, ctl});
      n = 0;
      do begin
         wb_go(1'b0, ADR_STATUS, 32'h0, q);
         n++;
      end while (q[STAT_DONE] !== 1'b1 && n < 20);
      check({23'h0, q[8:0]}, {23'h0, stat});
      check({28'h0, flag_v, flag_s, flag_z, flag_c}, {28'h0, stat[7:4]});
      if (q[STAT_DONE] !== 1'b1) begin
         error_cnt++;
         summarize();
      end
   endtask : exec

   // Main sequence: reset, then runs of register, immediate and decrement forms and one illegal word.
   initial begin
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      expect_rd(ADR_CTRL, 32'h00000010);
      expect_rd(ADR_STATUS, 32'h00000000);
      expect_rd(8'hF0, 32'h00000000);
      wr(ADR_GPR0 + 8'h04, 32'h00000002);
      wr(ADR_GPR0 + 8'h08, 32'h00000003);
      exec({7'h45, 1'b1, 4'h2, 4'h1}, ZW, ZW, ZW, 8'h11, 9'h052);
      expect_rd(ADR_GPR0 + 8'h04, 32'h00000002);
      expect_rd(ADR_GPR0 + 8'h08, 32'h00000003);
      wr(ADR_GPR0 + 8'h04, 32'h00000155);
      wr(ADR_GPR0 + 8'h08, 32'h0000AA55);
      exec({7'h45, 1'b0, 4'h2, 4'h1}, ZW, ZW, ZW, 8'h11, 9'h022);
      wr(ADR_GPR0 + 8'h0C, 32'h12345678);
      exec(16'h1003, 16'h1234, 16'h5678, ZW, 8'h11, 9'h022);
      wr(ADR_MEMOP, 32'h00008000);
      exec(16'h0D51, 16'h0001, ZW, ZW, 8'h11, 9'h082);
      expect_rd(ADR_MEMOP, 32'h00008000);
      wr(ADR_MEMOP, 32'h00000001);
      exec(16'h0D53, 16'h0000, 16'h0002, ZW, 8'h11, 9'h052);
      wr(ADR_MEMOP, 32'h00008000);
      exec(16'h4D71, 16'hFFFF, 16'hFFFF, 16'h8000, 8'h21, 9'h022);
      // A zero pointer field is no legal form: flags stay, illegal is set.
      exec(16'h0D01, 16'h0001, ZW, ZW, 8'h11, 9'h026);
      // Byte decrement form, compact pointer keeps its upper half.
      wr(ADR_GPR0 + 8'h04, 32'h000000FF);
      wr(ADR_GPR0 + 8'h08, 32'hAAAA0005);
      wr(ADR_GPR0 + 8'h0C, 32'h55550001);
      wr(ADR_MEMOP, 32'h00000000);
      exec(16'hBA28, 16'h0316, ZW, ZW, 8'h11, 9'h1C2);
      expect_rd(ADR_GPR0 + 8'h08, 32'hAAAA0004);
      expect_rd(ADR_GPR0 + 8'h0C, 32'h55550000);
      expect_rd(ADR_GPR0 + 8'h04, 32'h000000FF);
      // Word decrement form, not-equal code, pointer wraps in 16 bits.
      wr(ADR_GPR0 + 8'h04, 32'h00000003);
      wr(ADR_GPR0 + 8'h08, 32'h00000001);
      wr(ADR_GPR0 + 8'h0C, 32'h00000000);
      wr(ADR_MEMOP, 32'h00000005);
      exec(16'hBB28, 16'h031E, ZW, ZW, 8'h11, 9'h172);
      expect_rd(ADR_GPR0 + 8'h08, 32'h0000FFFF);
      expect_rd(ADR_GPR0 + 8'h0C, 32'h0000FFFF);
      // Long decrement form in linear mode, full 32-bit pointer.
      wr(ADR_GPR0 + 8'h10, 32'h00010002);
      wr(ADR_GPR0 + 8'h14, 32'h12340005);
      wr(ADR_GPR0 + 8'h18, 32'h80000000);
      wr(ADR_MEMOP, 32'h80000000);
      exec(16'hB948, 16'h0566, ZW, ZW, 8'h13, 9'h122);
      expect_rd(ADR_GPR0 + 8'h10, 32'h0000FFFE);
      expect_rd(ADR_GPR0 + 8'h14, 32'h12340004);
      summarize();
   end
endmodule : tb_cmpx_exec

// [verilog/cmpx_exec.sv]
// Compare instruction decoder and executor with a Wishbone register slave.
module cmpx_exec
   import cmpx_pkg::*;
(
   input wire logic core_clk, // Core clock, 125 MHz.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [7:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   output logic busy, // Instruction in progress.
   output logic flag_c, // Carry flag.
   output logic flag_z, // Zero flag.
   output logic flag_s, // Sign flag.
   output logic flag_v // Overflow flag.
);
   logic ack_ff;
   logic gpr_rd_ff;
   logic [31:0] dat_ff;
   logic [1:0] mode_ff;
   logic [1:0] ext_ff;
   logic [31:0] memop_ff;
   logic [15:0] iword_ff [IWORD_NUM];
   cmpx_state_t state_ff;
   logic done_ff, illegal_ff, cpd_ff;
   logic c_ff, z_ff, s_ff, v_ff;
   cmpx_size_t size_ff;
   cmpx_src_t src_ff;
   logic dst_reg_ff;
   logic [3:0] ra_ff, rb_ff, rc_ff, cc_ff;
   logic [2:0] idx_ff;
   logic [31:0] opa_ff, opb_ff, cnt_ff;
   logic [31:0] mem_rdata, mem_wdata;
   logic [3:0] mem_lane;
   logic [3:0] mem_addr;

   // Keeps bytes whose select is low, takes the new ones otherwise.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Zero-extends the operand to its size.
   function automatic logic [31:0] size_mask(input logic [31:0] v,
      input cmpx_size_t sz);
      case (sz)
         SZ_BYTE: size_mask = {24'h000000, v[7:0]};
         SZ_WORD: size_mask = {16'h0000, v[15:0]};
         default: size_mask = v;
      endcase
   endfunction : size_mask

   // Most significant bit at the operand size.
   function automatic logic msb_of(input logic [31:0] v,
      input cmpx_size_t sz);
      case (sz)
         SZ_BYTE: msb_of = v[7];
         SZ_WORD: msb_of = v[15];
         default: msb_of = v[31];
      endcase
   endfunction : msb_of

   // Evaluates a condition code; the top code bit inverts the test.
   function automatic logic cond_true(input logic [3:0] cc, input logic c,
      input logic z, input logic s, input logic v);
      logic base;
      case (cmpx_cond_t'(cc[2:0]))
         CC_F: base = 1'b0;
         CC_LT: base = s ^ v;
         CC_LE: base = z | (s ^ v);
         CC_ULE: base = c | z;
         CC_OV: base = v;
         CC_MI: base = s;
         CC_EQ: base = z;
         default: base = c;
      endcase
      return base ^ cc[3];
   endfunction : cond_true

   // Bus decode; writes take effect at the edge that sees ack high.
   logic bus_req, bus_wr, bus_take, hit_gpr, hit_iw;
   logic [2:0] iw_sel;
   logic start;
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & ack_ff;
   assign bus_take = bus_req & ~ack_ff;
   assign hit_gpr = (wb_adr_i[7:6] == ADR_GPR0[7:6]);
   assign iw_sel = 3'((wb_adr_i[7:2] - ADR_IWORD0[7:2]));
   assign hit_iw = (wb_adr_i >= ADR_IWORD0) &&
      (wb_adr_i < ADR_IWORD0 + 8'(IWORD_NUM * 4));
   assign busy = (state_ff != S_IDLE);
   assign start = bus_wr && !busy && wb_adr_i[7:2] == ADR_CTRL[7:2] &&
      wb_sel_i[0] && wb_dat_i[CTRL_START];

   // Acknowledge one cycle after the request, dropped the cycle after.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_take;
      end
   end
   assign wb_ack_o = ack_ff;

   // Read data is sampled when the request is taken.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         dat_ff <= 32'h00000000;
         gpr_rd_ff <= 1'b0;
      end else if (bus_take) begin
         gpr_rd_ff <= hit_gpr & ~busy;
         dat_ff <= 32'h00000000;
         if (hit_iw) begin
            dat_ff <= {16'h0000, iword_ff[iw_sel]};
         end else if (wb_adr_i[7:2] == ADR_CTRL[7:2]) begin
            dat_ff <= {26'h0, ext_ff, 1'b0, mode_ff, 1'b0};
         end else if (wb_adr_i[7:2] == ADR_MEMOP[7:2]) begin
            dat_ff <= memop_ff;
         end else if (wb_adr_i[7:2] == ADR_STATUS[7:2]) begin
            dat_ff[STAT_BUSY] <= busy;
            dat_ff[STAT_DONE] <= done_ff;
            dat_ff[STAT_ILLEGAL] <= illegal_ff;
            dat_ff[STAT_C] <= c_ff;
            dat_ff[STAT_Z] <= z_ff;
            dat_ff[STAT_S] <= s_ff;
            dat_ff[STAT_V] <= v_ff;
            dat_ff[STAT_CPD] <= cpd_ff;
         end
      end
   end
   assign wb_dat_o = gpr_rd_ff ? mem_rdata : dat_ff;

   // Software-owned registers are frozen while an instruction runs.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mode_ff <= CTRL_MODE_RST;
         ext_ff <= CTRL_EXT_RST;
         memop_ff <= 32'h00000000;
         for (int i = 0; i < IWORD_NUM; i++) begin
            iword_ff[i] <= 16'h0000;
         end
      end else if (bus_wr && !busy) begin
         if (wb_adr_i[7:2] == ADR_CTRL[7:2] && wb_sel_i[0]) begin
            mode_ff <= wb_dat_i[CTRL_MODE_LSB +: 2];
            ext_ff <= wb_dat_i[CTRL_EXT_LSB +: 2];
         end
         if (wb_adr_i[7:2] == ADR_MEMOP[7:2]) begin
            memop_ff <= merge(memop_ff, wb_dat_i, wb_sel_i);
         end
         if (hit_iw) begin
            iword_ff[iw_sel] <= 16'(merge({16'h0000, iword_ff[iw_sel]},
               wb_dat_i, wb_sel_i));
         end
      end
   end

   // Opcode decode of the first two instruction words.
   logic d_ok, d_dst_reg, d_cpd;
   cmpx_size_t d_size;
   cmpx_src_t d_src;
   logic [3:0] d_ra, d_rb, d_rc;
   logic [2:0] d_idx;
   logic [15:0] op, w2;
   always_comb begin
      op = iword_ff[0];
      w2 = iword_ff[1];
      d_ok = 1'b1;
      d_size = op[8] ? SZ_WORD : SZ_BYTE;
      d_src = SRC_MEM;
      d_dst_reg = 1'b1;
      d_cpd = 1'b0;
      d_ra = op[3:0];
      d_rb = op[7:4];
      d_rc = w2[11:8];
      d_idx = 3'd1;
      if (op[15:9] == OPC_CP_REG) begin
         d_src = SRC_REG;
      end else if (op[15:8] == OPC_CPL_REG) begin
         d_src = SRC_REG;
         d_size = SZ_LONG;
      end else if ((op[15:8] == OPC_CP_IM || op[15:8] == OPC_CPB_IM) &&
         op[7:4] == 4'h0) begin
         d_src = SRC_IMM;
      end else if (op[15:8] == OPC_CPL_IR) begin
         d_src = (op[7:4] == 4'h0) ? SRC_IMM : SRC_MEM;
         d_size = SZ_LONG;
      end else if (op[15:9] == OPC_CP_IR || op[15:9] == OPC_CP_EAM) begin
         d_src = SRC_MEM;
      end else if (op[15:8] == OPC_CPL_EAM) begin
         d_size = SZ_LONG;
      end else if ((op[15:8] == OPC_CPI_W && op[7:4] != 4'h0 &&
         (op[3:0] == NIB_IMM_WORD || op[3:0] == NIB_IMM_LONG)) ||
         (op[15:8] == OPC_CPI_B && op[7:4] != 4'h0 &&
         op[3:0] == NIB_IMM_WORD)) begin
         d_src = SRC_IMM;
         d_dst_reg = 1'b0;
         d_size = (op[3:0] == NIB_IMM_LONG) ? SZ_LONG : d_size;
      end else if ((op[15:8] == OPC_CPI_EAM_W &&
         (op[3:0] == NIB_IMM_WORD || op[3:0] == NIB_IMM_LONG)) ||
         (op[15:8] == OPC_CPI_EAM_B && op[3:0] == NIB_IMM_WORD)) begin
         d_src = SRC_IMM;
         d_dst_reg = 1'b0;
         d_size = (op[3:0] == NIB_IMM_LONG) ? SZ_LONG : d_size;
         d_idx = 3'd1 + ((ext_ff == 2'h0) ? 3'd1 : {1'b0, ext_ff});
      end else if ((op[15:9] == OPC_CPD || op[15:8] == OPC_COMPARE_DECREMENT_LONG) &&
         op[3:0] == NIB_CPD && op[7:4] != 4'h0 &&
         w2[15:12] == 4'h0) begin
         d_cpd = 1'b1;
         d_ra = w2[7:4];
         d_size = (op[15:8] == OPC_COMPARE_DECREMENT_LONG) ? SZ_LONG : d_size;
      end else begin
         d_ok = 1'b0;
      end
   end

   // Instruction sequencer.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_ff <= S_IDLE;
      end else begin
         case (state_ff)
            S_IDLE: state_ff <= start ? S_DECODE : S_IDLE;
            S_DECODE: state_ff <= d_ok ? S_RDA : S_IDLE;
            S_RDA: state_ff <= S_RDB;
            S_RDB: state_ff <= S_RDC;
            S_RDC: state_ff <= S_EXEC;
            S_EXEC: state_ff <= cpd_ff ? S_WPTR : S_IDLE;
            S_WPTR: state_ff <= S_WCNT;
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // Decoded fields are held for the whole instruction.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         size_ff <= SZ_WORD;
         src_ff <= SRC_REG;
         dst_reg_ff <= 1'b1;
         cpd_ff <= 1'b0;
         illegal_ff <= 1'b0;
         ra_ff <= 4'h0;
         rb_ff <= 4'h0;
         rc_ff <= 4'h0;
         cc_ff <= 4'h0;
         idx_ff <= 3'd1;
      end else if (state_ff == S_DECODE) begin
         size_ff <= d_size;
         src_ff <= d_src;
         dst_reg_ff <= d_dst_reg;
         cpd_ff <= d_cpd & d_ok;
         illegal_ff <= ~d_ok;
         ra_ff <= d_ra;
         rb_ff <= d_rb;
         rc_ff <= d_rc;
         cc_ff <= w2[3:0];
         idx_ff <= d_idx;
      end
   end

   // Register reads are pipelined: data arrives one state after its address.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         opa_ff <= 32'h00000000;
         opb_ff <= 32'h00000000;
         cnt_ff <= 32'h00000000;
      end else begin
         if (state_ff == S_RDB) opa_ff <= mem_rdata;
         if (state_ff == S_RDC) opb_ff <= mem_rdata;
         if (state_ff == S_EXEC) cnt_ff <= mem_rdata;
      end
   end

   // Operand selection and subtraction.
   logic [31:0] imm, a_v, b_v, diff, step, ptr_new;
   logic [15:0] cnt_dec, cnt_old;
   logic borrow, sgn, zero, ovf;
   always_comb begin
      case (size_ff)
         SZ_BYTE: imm = {24'h000000, iword_ff[idx_ff][7:0]};
         SZ_WORD: imm = {16'h0000, iword_ff[idx_ff]};
         default: imm = {iword_ff[idx_ff], iword_ff[idx_ff + 3'd1]};
      endcase
      a_v = size_mask(dst_reg_ff ? opa_ff : memop_ff, size_ff);
      case (src_ff)
         SRC_REG: b_v = size_mask(opb_ff, size_ff);
         SRC_IMM: b_v = imm;
         default: b_v = size_mask(memop_ff, size_ff);
      endcase
      diff = size_mask(a_v - b_v, size_ff);
      borrow = (a_v < b_v);
      sgn = msb_of(diff, size_ff);
      zero = (diff == 32'h00000000);
      ovf = (msb_of(a_v, size_ff) ^ msb_of(b_v, size_ff)) &
         (sgn ^ msb_of(a_v, size_ff));
      cnt_old = (state_ff == S_EXEC) ? mem_rdata[15:0] : cnt_ff[15:0];
      cnt_dec = cnt_old - COUNT_STEP;
   end

   always_comb begin
      case (size_ff)
         SZ_BYTE: step = STEP_BYTE;
         SZ_WORD: step = STEP_WORD;
         default: step = STEP_LONG;
      endcase
      if (mode_ff == MODE_COMPACT) begin
         ptr_new = {opb_ff[31:16], opb_ff[15:0] - step[15:0]};
      end else begin
         ptr_new = opb_ff - step;
      end
   end

   // Flags change only in the execute state.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         c_ff <= 1'b0;
         z_ff <= 1'b0;
         s_ff <= 1'b0;
         v_ff <= 1'b0;
      end else if (state_ff == S_EXEC) begin
         c_ff <= borrow;
         s_ff <= sgn;
         z_ff <= cpd_ff ? cond_true(cc_ff, borrow, zero, sgn, ovf) : zero;
         v_ff <= cpd_ff ? (cnt_dec == 16'h0000) : ovf;
      end
   end
   assign flag_c = c_ff;
   assign flag_z = z_ff;
   assign flag_s = s_ff;
   assign flag_v = v_ff;

   // Done rises when the sequencer returns to idle; a new start clears it.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         done_ff <= 1'b0;
      end else if ((state_ff == S_DECODE && !d_ok) || state_ff == S_WCNT ||
         (state_ff == S_EXEC && !cpd_ff)) begin
         done_ff <= 1'b1;
      end else if (start) begin
         done_ff <= 1'b0;
      end
   end

   // while busy, only pointer and counter are written
   always_comb begin
      mem_addr = wb_adr_i[5:2];
      mem_lane = (bus_wr && hit_gpr) ? wb_sel_i : 4'h0;
      mem_wdata = wb_dat_i;
      if (busy) begin
         mem_lane = 4'h0;
         case (state_ff)
            S_RDB: mem_addr = rb_ff;
            S_RDC: mem_addr = rc_ff;
            S_WPTR: begin
               mem_addr = rb_ff;
               mem_lane = 4'hF;
               mem_wdata = ptr_new;
            end
            S_WCNT: begin
               mem_addr = rc_ff;
               mem_lane = 4'hF;
               mem_wdata = {cnt_ff[31:16], cnt_dec};
            end
            default: mem_addr = ra_ff;
         endcase
      end
   end

   // General registers, shared between the bus and the sequencer.
   cmpx_regfile #(
      .DEPTH(GPR_NUM),
      .AW(4),
      .LANES(4)
   ) u_regs (
      .core_clk(core_clk),
      .nrst(nrst),
      .addr(mem_addr),
      .wr_lane(mem_lane),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );
endmodule : cmpx_exec

// [verilog/cmpx_pkg.sv]
// Register map, field layout, opcodes and types of the compare unit.
package cmpx_pkg;
   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_MEMOP = 8'h08;
   localparam logic [7:0] ADR_IWORD0 = 8'h0C;
   localparam logic [7:0] ADR_GPR0 = 8'h40;
   localparam int IWORD_NUM = 6;
   localparam int GPR_NUM = 16;
   // Control register fields and reset values.
   localparam int CTRL_START = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_EXT_LSB = 4;
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;
   localparam logic [1:0] CTRL_EXT_RST = 2'h1;
   localparam logic [1:0] MODE_COMPACT = 2'h0;
   // Status register fields.
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ILLEGAL = 2;
   localparam int STAT_C = 4;
   localparam int STAT_Z = 5;
   localparam int STAT_S = 6;
   localparam int STAT_V = 7;
   localparam int STAT_CPD = 8;
   // Opcode patterns, upper seven or eight bits or low nibble of the opcode word.
   localparam logic [6:0] OPC_CP_REG = 7'h45;
   localparam logic [6:0] OPC_CP_IR = 7'h05;
   localparam logic [6:0] OPC_CP_EAM = 7'h25;
   localparam logic [6:0] OPC_CPD = 7'h5D;
   localparam logic [7:0] OPC_CPL_REG = 8'h90;
   localparam logic [7:0] OPC_CPL_IR = 8'h10;
   localparam logic [7:0] OPC_CPL_EAM = 8'h50;
   localparam logic [7:0] OPC_CP_IM = 8'h0B;
   localparam logic [7:0] OPC_CPB_IM = 8'h0A;
   localparam logic [7:0] OPC_CPI_W = 8'h0D;
   localparam logic [7:0] OPC_CPI_B = 8'h0C;
   localparam logic [7:0] OPC_CPI_EAM_W = 8'h4D;
   localparam logic [7:0] OPC_CPI_EAM_B = 8'h4C;
   localparam logic [7:0] OPC_COMPARE_DECREMENT_LONG = 8'hB9;
   localparam logic [3:0] NIB_CPD = 4'h8;
   localparam logic [3:0] NIB_IMM_WORD = 4'h1;
   localparam logic [3:0] NIB_IMM_LONG = 4'h3;
   // Pointer and counter steps.
   localparam logic [31:0] STEP_BYTE = 32'h00000001;
   localparam logic [31:0] STEP_WORD = 32'h00000002;
   localparam logic [31:0] STEP_LONG = 32'h00000004;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10
   } cmpx_size_t;
   typedef enum logic [1:0] {
      SRC_REG = 2'b00, SRC_IMM = 2'b01, SRC_MEM = 2'b10
   } cmpx_src_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_DECODE = 3'b001, S_RDA = 3'b010, S_RDB = 3'b011,
      S_RDC = 3'b100, S_EXEC = 3'b101, S_WPTR = 3'b110, S_WCNT = 3'b111
   } cmpx_state_t;
   // Codes 8 to 15 are the complements of codes 0 to 7.
   typedef enum logic [2:0] {
      CC_F = 3'b000, CC_LT = 3'b001, CC_LE = 3'b010, CC_ULE = 3'b011,
      CC_OV = 3'b100, CC_MI = 3'b101, CC_EQ = 3'b110, CC_ULT = 3'b111
   } cmpx_cond_t;
endpackage : cmpx_pkg

// [verilog/cmpx_regfile.sv]
// General register file with byte-lane writes and a registered read port.
module cmpx_regfile #(
   parameter int DEPTH = 16,
   parameter int AW = 4,
   parameter int LANES = 4
) (
   input wire logic core_clk, // Core clock.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic [AW-1:0] addr, // Shared read and write address.
   input wire logic [LANES-1:0] wr_lane, // Byte-lane write enables.
   input wire logic [LANES*8-1:0] wdata, // Write data.
   output logic [LANES*8-1:0] rdata // Read data, one cycle late.
);
   genvar gi;
   // One narrow array per lane keeps each array under a single driver.
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         logic [7:0] lane_mem [DEPTH];
         logic [7:0] q_ff;
         always_ff @(posedge core_clk) begin
            if (wr_lane[gi]) begin
               lane_mem[addr] <= wdata[gi*8 +: 8];
            end
         end
         // Read returns the old contents when written in the same cycle.
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               q_ff <= 8'h00;
            end else begin
               q_ff <= lane_mem[addr];
            end
         end
         // Each lane drives only its own slice of the read port.
         assign rdata[gi*8 +: 8] = q_ff;
      end
   endgenerate
endmodule : cmpx_regfile
